// ==== shared/ssa_pkg.sv ====
package ssa_pkg;

    localparam int DATA_W = 8;

    // First control register: fully readable and writable.
    localparam logic [7:0] CTL1_RESET    = 8'h00;
    localparam int         CTL1_EN_BIT   = 5;
    localparam int         CTL1_I2C_BIT  = 3;

    // Status register: upper two bits writable, lower six read-only.
    localparam logic [7:0] STAT_RW_RESET = 8'h00;
    localparam int         STAT_RW_HI    = 7;
    localparam int         STAT_RW_LO    = 6;
    localparam int         STAT_STOP_BIT = 4;
    localparam int         STAT_STRT_BIT = 3;
    localparam int         STAT_BUSY_BIT = 2;
    localparam int         STAT_BF_BIT   = 0;

    // Second control register: sequence requests and acknowledge data.
    localparam logic [7:0] CTL2_RESET    = 8'h00;
    localparam int         C2_START_BIT  = 0;
    localparam int         C2_RSTRT_BIT  = 1;
    localparam int         C2_STOP_BIT   = 2;
    localparam int         C2_ACKEN_BIT  = 4;
    localparam int         C2_ACKDT_BIT  = 5;
    localparam logic [7:0] C2_REQ_MASK   = 8'h17;

    localparam logic [7:0] BAUD_RESET    = 8'h00;
    localparam logic [7:0] BYTE_RESET    = 8'h00;

    // Bit counts and quarter phases of one bus bit.
    localparam logic [3:0] SPI_LAST_BIT  = 4'h7;
    localparam logic [3:0] I2C_ACK_SLOT  = 4'h8;
    localparam logic [3:0] RX_LAST_BIT   = 4'h7;
    localparam logic [1:0] Q_LAST        = 2'h3;
    localparam logic [1:0] Q_SAMPLE      = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_START  = 3'b001,
        ST_DATA   = 3'b011,
        ST_ACKOUT = 3'b010,
        ST_STOP   = 3'b110,
        ST_RSTART = 3'b111,
        ST_SPI    = 3'b101
    } ssa_state_t;

endpackage

// ==== design/ssa_sync2.sv ====
`timescale 1ns/10ps
module ssa_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // Both stages reset high: an idle open-drain bus reads high.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule

// ==== design/ssa_baud.sv ====
`timescale 1ns/10ps
module ssa_baud
    import ssa_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic             i_run,
    input  wire logic [WIDTH-1:0] i_reload,
    output logic                  o_tick
);
    logic [WIDTH-1:0] count_reg;

    // The count restarts from the reload value whenever the port is not
    // running, so the first bit of a transfer has a full period.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_reg <= '0;
        end else if (!i_run || count_reg == '0) begin
            count_reg <= i_reload;
        end else begin
            count_reg <= count_reg - WIDTH'(1);
        end
    end

    assign o_tick = i_run && (count_reg == '0);
endmodule

// ==== design/ssa_port.sv ====
`timescale 1ns/10ps
module ssa_port
    import ssa_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_ctrl1_wr,
    input  wire logic [7:0]  i_ctrl1_wdata,
    output logic      [7:0]  o_ctrl1,
    input  wire logic        i_stat_wr,
    input  wire logic [7:0]  i_stat_wdata,
    output logic      [7:0]  o_status,
    input  wire logic        i_ctrl2_wr,
    input  wire logic [7:0]  i_ctrl2_wdata,
    output logic      [7:0]  o_ctrl2,
    input  wire logic        i_baud_wr,
    input  wire logic [7:0]  i_baud_wdata,
    output logic      [7:0]  o_baud,
    input  wire logic        i_buf_wr,
    input  wire logic [7:0]  i_buf_wdata,
    input  wire logic        i_buf_rd,
    output logic      [7:0]  o_buf_rdata,
    input  wire logic        i_irq_enable,
    input  wire logic        i_irq_clr,
    output logic             o_irq_flag,
    input  wire logic        i_bcl_clr,
    output logic             o_bus_collision_flag,
    input  wire logic        i_sleep,
    output logic             o_wake,
    output logic             o_sck,
    output logic             o_sdo,
    input  wire logic        i_sdi,
    input  wire logic        i_scl,
    output logic             o_scl,
    output logic             o_scl_oe_n,
    input  wire logic        i_sda,
    output logic             o_sda,
    output logic             o_sda_oe_n
);

    typedef struct packed {
        ssa_state_t st;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] baud;
        logic [7:0] data_buf;
        logic [7:0] sr;
        logic [1:0] stat_rw;
        logic [1:0] q;
        logic [3:0] bitcnt;
        logic [3:0] rxcnt;
        logic       bf;
        logic       tx_pend;
        logic       irq;
        logic       bcl;
        logic       bcl_wait;
        logic       armed;
        logic       start_det;
        logic       stop_det;
        logic       addr_phase;
        logic       slave_sel;
        logic       scl_prev;
        logic       sda_prev;
        logic       scl_rel;
        logic       sda_rel;
        logic       sck;
        logic       rx_bit;
        logic       wake;
    } ssa_regs_t;

    ssa_regs_t r_reg;
    ssa_regs_t r_next;
    logic      tick;
    logic      scl_s;
    logic      sda_s;
    logic      sdi_s;
    logic      running;

    // Wanted line levels {scl released, sda released} per quarter of a bit.
    function automatic logic [1:0] line_levels(ssa_state_t st,
                                               logic [1:0] q,
                                               logic       bit_val);
        logic [1:0] lv;
        lv = 2'b11;
        case (st)
            ST_START: begin
                case (q)
                    2'h2:    lv = 2'b10;
                    2'h3:    lv = 2'b00;
                    default: lv = 2'b11;
                endcase
            end
            ST_RSTART: begin
                case (q)
                    2'h0:    lv = 2'b01;
                    2'h1:    lv = 2'b11;
                    2'h2:    lv = 2'b10;
                    default: lv = 2'b00;
                endcase
            end
            ST_DATA, ST_ACKOUT: begin
                case (q)
                    2'h1, 2'h2: lv = {1'b1, bit_val};
                    default:    lv = {1'b0, bit_val};
                endcase
            end
            ST_STOP: begin
                case (q)
                    2'h0:    lv = 2'b00;
                    2'h1:    lv = 2'b10;
                    default: lv = 2'b11;
                endcase
            end
            default: lv = 2'b11;
        endcase
        return lv;
    endfunction

    // Bit that the master offers on SDA in its current state.
    function automatic logic tx_bit(ssa_regs_t s);
        logic b;
        b = 1'b1;
        case (s.st)
            ST_DATA:   b = (s.bitcnt == I2C_ACK_SLOT) ? 1'b1 : s.sr[7];
            ST_ACKOUT: b = s.ctrl2[C2_ACKDT_BIT];
            default:   b = 1'b1;
        endcase
        return b;
    endfunction

    ssa_sync2 #(
        .WIDTH (3)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async ({i_scl, i_sda, i_sdi}),
        .o_sync  ({scl_s, sda_s, sdi_s})
    );

    assign running = (r_reg.st != ST_IDLE);

    ssa_baud #(
        .WIDTH (DATA_W)
    ) u_baud (
        .i_clock  (i_clock),
        .i_rst    (i_rst),
        .i_run    (running),
        .i_reload (r_reg.baud),
        .o_tick   (tick)
    );

    always_comb begin
        logic       en;
        logic       i2c;
        logic       irq_set;
        logic       bcl_set;
        logic       start_ev;
        logic       stop_ev;
        logic       bus_free;
        logic       collide;
        logic [7:0] rx_byte;
        logic [1:0] lv;
        en       = r_reg.ctrl1[CTL1_EN_BIT];
        i2c      = r_reg.ctrl1[CTL1_I2C_BIT];
        irq_set  = 1'b0;
        bcl_set  = 1'b0;
        collide  = 1'b0;
        rx_byte  = {r_reg.sr[6:0], sda_s};
        r_next   = r_reg;

        if (i_ctrl1_wr) begin
            r_next.ctrl1 = i_ctrl1_wdata;
        end
        if (i_stat_wr) begin
            r_next.stat_rw = i_stat_wdata[STAT_RW_HI:STAT_RW_LO];
        end
        if (i_baud_wr) begin
            r_next.baud = i_baud_wdata;
        end

        // Start and Stop are watched in every state while enabled in I2C mode, also after a collision.
        r_next.scl_prev = scl_s;
        r_next.sda_prev = sda_s;
        start_ev = en && i2c && scl_s && r_reg.scl_prev
                   && r_reg.sda_prev && !sda_s;
        stop_ev  = en && i2c && scl_s && r_reg.scl_prev
                   && !r_reg.sda_prev && sda_s;
        bus_free = r_reg.stop_det
                   || (!r_reg.start_det && !r_reg.stop_det);
        if (i_irq_enable && r_reg.start_det) begin
            r_next.armed = 1'b1;
        end
        if (start_ev) begin
            r_next.start_det  = 1'b1;
            r_next.stop_det   = 1'b0;
            r_next.rxcnt      = '0;
            r_next.addr_phase = 1'b1;
        end
        if (stop_ev) begin
            r_next.stop_det  = 1'b1;
            r_next.start_det = 1'b0;
            r_next.slave_sel = 1'b0;
            if (r_next.armed || r_reg.bcl_wait) begin
                irq_set = 1'b1;
            end
            r_next.armed    = 1'b0;
            r_next.bcl_wait = 1'b0;
        end

        if (i_buf_rd) begin
            r_next.bf = 1'b0;
        end

        case (r_reg.st)
            ST_IDLE: begin
                if (en && i_buf_wr) begin
                    // Bit count restarts at zero on every new write.
                    r_next.data_buf = i_buf_wdata;
                    r_next.sr       = i_buf_wdata;
                    r_next.bitcnt   = '0;
                    r_next.q        = '0;
                    r_next.bf       = 1'b1;
                    if (i2c) begin
                        r_next.tx_pend = 1'b1;
                    end else begin
                        r_next.st  = ST_SPI;
                        r_next.sck = 1'b0;
                    end
                end else if (en && i2c) begin
                    r_next.q = '0;
                    if (r_reg.ctrl2[C2_START_BIT] && bus_free) begin
                        r_next.st = ST_START;
                    end else if (r_reg.ctrl2[C2_RSTRT_BIT]) begin
                        r_next.st = ST_RSTART;
                    end else if (r_reg.ctrl2[C2_STOP_BIT]) begin
                        r_next.st = ST_STOP;
                    end else if (r_reg.ctrl2[C2_ACKEN_BIT]) begin
                        r_next.st = ST_ACKOUT;
                    end else if (r_reg.tx_pend) begin
                        r_next.st      = ST_DATA;
                        r_next.tx_pend = 1'b0;
                    end else if (scl_s && !r_reg.scl_prev && !start_ev) begin
                        // Slave side samples on each rising SCL, also in
                        // sleep; the ninth clock is the acknowledge slot.
                        if (r_reg.rxcnt == I2C_ACK_SLOT) begin
                            r_next.rxcnt = '0;
                        end else begin
                            r_next.sr    = rx_byte;
                            r_next.rxcnt = r_reg.rxcnt + 4'h1;
                            if (r_reg.rxcnt == RX_LAST_BIT) begin
                                if (r_reg.addr_phase) begin
                                    r_next.addr_phase = 1'b0;
                                    r_next.slave_sel  =
                                        (rx_byte[7:1] == r_reg.baud[7:1]);
                                end
                                if (!r_reg.addr_phase || rx_byte[7:1]
                                        == r_reg.baud[7:1]) begin
                                    if (r_reg.slave_sel || r_reg.addr_phase)
                                    begin
                                        r_next.data_buf = rx_byte;
                                        r_next.bf       = 1'b1;
                                        irq_set         = 1'b1;
                                    end
                                end
                            end
                        end
                    end
                end
            end
            ST_SPI: begin
                if (tick) begin
                    if (!r_reg.sck) begin
                        r_next.sck    = 1'b1;
                        r_next.rx_bit = sdi_s;
                    end else begin
                        r_next.sck = 1'b0;
                        r_next.sr  = {r_reg.sr[6:0], r_reg.rx_bit};
                        if (r_reg.bitcnt == SPI_LAST_BIT) begin
                            r_next.data_buf = {r_reg.sr[6:0], r_reg.rx_bit};
                            r_next.bf       = 1'b1;
                            irq_set         = 1'b1;
                            r_next.st       = ST_IDLE;
                        end else begin
                            r_next.bitcnt = r_reg.bitcnt + 4'h1;
                        end
                    end
                end
            end
            default: begin
                // Released SDA must read high while SCL is really high;
                // the acknowledge slot of a written byte is the slave's.
                collide = r_reg.scl_rel && r_reg.sda_rel && scl_s && !sda_s
                          && !(r_reg.st == ST_DATA
                               && r_reg.bitcnt == I2C_ACK_SLOT);
                if (tick && collide) begin
                    bcl_set         = 1'b1;
                    r_next.bcl_wait = 1'b1;
                    r_next.st       = ST_IDLE;
                    r_next.tx_pend  = 1'b0;
                    r_next.q        = '0;
                    if (r_reg.st == ST_DATA) begin
                        r_next.bf = 1'b0;
                    end
                    r_next.ctrl2 = r_reg.ctrl2 & ~C2_REQ_MASK;
                end else if (tick && !(r_reg.scl_rel && !scl_s)) begin
                    // A slave holding SCL low stretches the quarter.
                    if (r_reg.st == ST_DATA && r_reg.q == Q_SAMPLE
                            && r_reg.bitcnt != I2C_ACK_SLOT) begin
                        r_next.sr = rx_byte;
                    end
                    if (r_reg.q != Q_LAST) begin
                        r_next.q = r_reg.q + 2'h1;
                    end else begin
                        r_next.q  = '0;
                        r_next.st = ST_IDLE;
                        case (r_reg.st)
                            ST_START:
                                r_next.ctrl2[C2_START_BIT] = 1'b0;
                            ST_RSTART:
                                r_next.ctrl2[C2_RSTRT_BIT] = 1'b0;
                            ST_STOP:
                                r_next.ctrl2[C2_STOP_BIT] = 1'b0;
                            ST_ACKOUT: begin
                                r_next.ctrl2[C2_ACKEN_BIT] = 1'b0;
                                irq_set = 1'b1;
                            end
                            ST_DATA: begin
                                if (r_reg.bitcnt == I2C_ACK_SLOT) begin
                                    r_next.bf = 1'b0;
                                    irq_set   = 1'b1;
                                end else begin
                                    r_next.st     = ST_DATA;
                                    r_next.bitcnt = r_reg.bitcnt + 4'h1;
                                end
                            end
                            default: r_next.st = ST_IDLE;
                        endcase
                    end
                end
            end
        endcase

        // Disabling the port aborts any transfer and forgets bus state.
        if (!en) begin
            r_next.st        = ST_IDLE;
            r_next.tx_pend   = 1'b0;
            r_next.sck       = 1'b0;
            r_next.q         = '0;
            r_next.start_det = 1'b0;
            r_next.stop_det  = 1'b0;
            r_next.slave_sel = 1'b0;
            r_next.armed     = 1'b0;
        end

        lv = line_levels(r_next.st, r_next.q, tx_bit(r_next));
        r_next.scl_rel = lv[1];
        r_next.sda_rel = lv[0];

        // A software write to the requests wins over a hardware clear.
        if (i_ctrl2_wr) begin
            r_next.ctrl2 = i_ctrl2_wdata;
        end
        // Setting wins over a clear arriving in the same cycle.
        r_next.irq  = (r_reg.irq && !i_irq_clr) || irq_set;
        r_next.bcl  = (r_reg.bcl && !i_bcl_clr) || bcl_set;
        r_next.wake = i_sleep && i_irq_enable && r_next.irq;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            r_reg          <= '0;
            r_reg.st       <= ST_IDLE;
            r_reg.ctrl1    <= CTL1_RESET;
            r_reg.ctrl2    <= CTL2_RESET;
            r_reg.baud     <= BAUD_RESET;
            r_reg.data_buf <= BYTE_RESET;
            r_reg.sr       <= BYTE_RESET;
            r_reg.stat_rw  <= STAT_RW_RESET[STAT_RW_HI:STAT_RW_LO];
            r_reg.scl_prev <= 1'b1;
            r_reg.sda_prev <= 1'b1;
            r_reg.scl_rel  <= 1'b1;
            r_reg.sda_rel  <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    always_comb begin
        o_status                = '0;
        o_status[STAT_RW_HI:STAT_RW_LO] = r_reg.stat_rw;
        o_status[STAT_STOP_BIT] = r_reg.stop_det;
        o_status[STAT_STRT_BIT] = r_reg.start_det;
        o_status[STAT_BUSY_BIT] = running;
        o_status[STAT_BF_BIT]   = r_reg.bf;
    end

    assign o_ctrl1              = r_reg.ctrl1;
    assign o_ctrl2              = r_reg.ctrl2;
    assign o_baud               = r_reg.baud;
    assign o_buf_rdata          = r_reg.data_buf;
    assign o_irq_flag           = r_reg.irq;
    assign o_bus_collision_flag = r_reg.bcl;
    assign o_wake               = r_reg.wake;
    assign o_sck                = r_reg.sck;
    assign o_sdo                = r_reg.sr[7];
    assign o_scl                = 1'b0;
    assign o_sda                = 1'b0;
    assign o_scl_oe_n           = r_reg.scl_rel;
    assign o_sda_oe_n           = r_reg.sda_rel;
endmodule

// ==== tb/ssa_i2c_peer.sv ====
`timescale 1ns/10ps
module ssa_i2c_peer (
    input  wire logic i_clock,
    input  wire logic i_scl_oe_n,
    input  wire logic i_sda_oe_n,
    input  wire logic i_hold_scl,
    input  wire logic i_hold_sda,
    input  wire logic i_frame,
    output logic      o_scl_line,
    output logic      o_sda_line
);
    logic scl_low_reg = 1'b0;
    logic sda_low_reg = 1'b0;
    // Both wires have pull-ups, so a released wire reads high.
    assign o_scl_line = i_scl_oe_n & ~scl_low_reg;
    assign o_sda_line = i_sda_oe_n & ~sda_low_reg;
    always @(posedge i_clock) begin
        scl_low_reg <= i_hold_scl;
        // Data moves only while the clock is low; framing is the one
        // deliberate exception, used to make Start and Stop.
        if (!o_scl_line || i_frame) begin
            sda_low_reg <= i_hold_sda;
        end
    end
endmodule

// ==== tb/ssa_port_asserts.sv ====
`timescale 1ns/10ps
module ssa_port_asserts
    import ssa_pkg::*;
(
    input wire logic       i_clock,
    input wire logic       i_rst,
    input wire logic       i_ctrl1_wr,
    input wire logic [7:0] i_ctrl1_wdata,
    input wire logic [7:0] o_ctrl1,
    input wire logic       i_stat_wr,
    input wire logic [7:0] i_stat_wdata,
    input wire logic [7:0] o_status,
    input wire logic [7:0] o_ctrl2,
    input wire logic       i_buf_wr,
    input wire logic [7:0] i_buf_wdata,
    input wire logic [7:0] o_buf_rdata,
    input wire logic       i_irq_enable,
    input wire logic       o_irq_flag,
    input wire logic       i_bcl_clr,
    input wire logic       o_bus_collision_flag,
    input wire logic       i_sleep,
    input wire logic       o_wake,
    input wire logic       o_sdo,
    input wire logic       o_scl_oe_n,
    input wire logic       o_sda_oe_n
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence s_quiet;
        o_sda_oe_n && o_scl_oe_n && !o_status[STAT_BUSY_BIT];
    endsequence
    sequence s_loaded;
        o_status[STAT_BF_BIT] && o_buf_rdata == $past(i_buf_wdata);
    endsequence
    a_ctrl1_write: assert property (i_ctrl1_wr |=>
        o_ctrl1 == $past(i_ctrl1_wdata)) else $error("control 1 lost");
    a_stat_upper: assert property (i_stat_wr |=>
        o_status[7:6] == $past(i_stat_wdata[7:6])) else $error("status");
    a_reset_clear: assert property ($fell(i_rst) |->
        o_ctrl1 == CTL1_RESET && o_status[4:3] == 2'b00 ##0 s_quiet)
        else $error("reset left state behind");
    a_buf_load: assert property (i_buf_wr && o_ctrl1[CTL1_EN_BIT] &&
        !o_status[STAT_BUSY_BIT] |=> s_loaded ##0
        (o_ctrl1[CTL1_I2C_BIT] || o_sdo == $past(i_buf_wdata[7])))
        else $error("buffer write not loaded");
    a_spi_done: assert property ($fell(o_status[STAT_BUSY_BIT]) &&
        o_ctrl1[CTL1_EN_BIT] && !o_ctrl1[CTL1_I2C_BIT] |->
        o_irq_flag && o_status[STAT_BF_BIT]) else $error("byte not posted");
    a_bcl_hold: assert property (o_bus_collision_flag && !i_bcl_clr
        |=> o_bus_collision_flag) else $error("collision flag dropped");
    a_bcl_idle: assert property ($rose(o_bus_collision_flag) |->
        ##[0:1] s_quiet ##0 (o_ctrl2 & C2_REQ_MASK) == 8'h00 &&
        !o_status[STAT_BF_BIT]) else $error("collision not idled");
    a_wake_up: assert property (i_sleep && i_irq_enable
        |=> o_wake == o_irq_flag) else $error("wake does not follow flag");
endmodule
bind ssa_port ssa_port_asserts ssa_port_asserts_i (.*);

// ==== tb/test_ssa_port.sv ====
`timescale 1ns/10ps
module test_ssa_port;
    import ssa_pkg::*;
    logic       i_clock = 1'b0;
    logic       i_rst = 1'b1;
    logic [7:0] wd = 8'h00;
    logic [7:0] wr = 8'h00;
    logic       en = 1'b0;
    logic       slp = 1'b0;
    logic       hs = 1'b0;
    logic       hd = 1'b0;
    logic       fr = 1'b0;
    logic [7:0] ctl1, stat, ctl2, baud, rdata;
    logic       irq, bcl, wake, sck, sdo, scl_oe_n, sda_oe_n, scl, sda;
    int         fail_count = 0;
    int         total_checks = 0;
    always #50 i_clock = ~i_clock;
    ssa_port ssa_port_i (.i_clock(i_clock), .i_rst(i_rst),
        .i_ctrl1_wr(wr[0]), .i_ctrl1_wdata(wd), .o_ctrl1(ctl1),
        .i_stat_wr(wr[1]), .i_stat_wdata(wd), .o_status(stat),
        .i_ctrl2_wr(wr[2]), .i_ctrl2_wdata(wd), .o_ctrl2(ctl2),
        .i_baud_wr(wr[3]), .i_baud_wdata(wd), .o_baud(baud),
        .i_buf_wr(wr[4]), .i_buf_wdata(wd), .i_buf_rd(wr[5]),
        .o_buf_rdata(rdata), .i_irq_enable(en), .i_irq_clr(wr[6]),
        .o_irq_flag(irq), .i_bcl_clr(wr[7]), .o_bus_collision_flag(bcl),
        .i_sleep(slp), .o_wake(wake), .o_sck(sck), .o_sdo(sdo),
        .i_sdi(sdo), .i_scl(scl), .o_scl(), .o_scl_oe_n(scl_oe_n),
        .i_sda(sda), .o_sda(), .o_sda_oe_n(sda_oe_n));
    ssa_i2c_peer ssa_i2c_peer_i (.i_clock(i_clock), .i_scl_oe_n(scl_oe_n),
        .i_sda_oe_n(sda_oe_n), .i_hold_scl(hs), .i_hold_sda(hd),
        .i_frame(fr), .o_scl_line(scl), .o_sda_line(sda));
    task tick;
        @(posedge i_clock);
        #1;
    endtask
    task put(input int k, input logic [7:0] d);
        @(posedge i_clock);
        wd <= d;
        wr <= 8'h01 << k;
        @(posedge i_clock);
        wr <= 8'h00;
        #1;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // The far master grabs SDA; framing lets it move SDA with SCL high.
    task grab;
        hd <= 1'b1;
        fr <= 1'b1;
        tick;
        fr <= 1'b0;
    endtask
    task bus_stop;
        hs <= 1'b1;
        hd <= 1'b1;
        repeat (4) tick;
        hs <= 1'b0;
        repeat (4) tick;
        fr <= 1'b1;
        hd <= 1'b0;
        repeat (4) tick;
        fr <= 1'b0;
    endtask
    task t_regs;
        put(1, 8'hff);
        chk(stat, 8'hc0);
        put(0, 8'h5a);
        chk(ctl1, 8'h5a);
        put(3, 8'h07);
        chk(baud, 8'h07);
    endtask
    task t_spi;
        int n;
        put(0, 8'h20);
        put(4, 8'ha5);
        chk({sdo, rdata[6:0]}, 8'ha5);
        for (n = 0; n < 3000 && stat[STAT_BUSY_BIT]; n++) tick;
        chk(n >= 120 && n <= 136, 1'b1);
        chk(rdata, 8'ha5);
        chk({irq, stat[STAT_BF_BIT]}, 2'b11);
        put(5, 8'h00);
        put(4, 8'h3c);
        repeat (20) tick;
        i_rst <= 1'b1;
        repeat (3) tick;
        i_rst <= 1'b0;
        tick;
        chk({ctl1[5:0], stat[STAT_BUSY_BIT], sck}, 8'h00);
    endtask
    task t_i2c;
        int n;
        put(0, 8'h28);
        put(3, 8'h01);
        en <= 1'b1;
        slp <= 1'b1;
        put(2, 8'h01);
        for (n = 0; n < 500 && ctl2[C2_START_BIT]; n++) tick;
        grab;
        put(4, 8'hff);
        for (n = 0; n < 500 && !bcl; n++) tick;
        chk({bcl, stat[STAT_BF_BIT], sda_oe_n, scl_oe_n}, 4'hb);
        put(6, 8'h00);
        bus_stop;
        for (n = 0; n < 50 && !irq; n++) tick;
        tick;
        chk({irq, wake, bcl}, 3'h7);
        put(7, 8'h00);
        chk(bcl, 1'b0);
        slp <= 1'b0;
        put(2, 8'h01);
        for (n = 0; n < 500 && ctl2[C2_START_BIT]; n++) tick;
        put(4, 8'h80);
        for (n = 0; n < 50 && scl_oe_n; n++) tick;
        chk(sda_oe_n, 1'b1);
        for (n = 0; n < 50 && !scl_oe_n; n++) tick;
        for (n = 0; n < 50 && scl_oe_n; n++) tick;
        chk(sda_oe_n, 1'b0);
        for (n = 0; n < 500 && stat[STAT_BUSY_BIT]; n++) tick;
        grab;
        put(2, 8'h02);
        for (n = 0; n < 500 && !bcl; n++) tick;
        chk({bcl, ctl2[6:0] & C2_REQ_MASK[6:0]}, 8'h80);
        put(2, 8'h01);
        repeat (40) tick;
        chk({ctl2[C2_START_BIT], sda_oe_n}, 2'b11);
        bus_stop;
        for (n = 0; n < 500 && ctl2[C2_START_BIT]; n++) tick;
        chk(ctl2[C2_START_BIT], 1'b0);
        chk(stat[4:3], 2'b01);
        put(0, 8'h00);
        tick;
        chk(stat[4:3], 2'b00);
    endtask
    initial begin
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        t_regs;
        t_spi;
        t_i2c;
        conclude;
    end
    initial begin
        #2000000;
        fail_count++;
        conclude;
    end
endmodule
